// ### dv/fwp_asserts.sv
// Assertion checker for the flash word program control block
`timescale 1ns/1ps
`default_nettype none
module fwp_asserts
  import fwp_pkg::*;
#(
  parameter int WRITE_CYCLES = FWP_WORD_WRITE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  input wire logic cpu_stall,
  input wire logic flash_prog_en,
  input wire logic [21:0] flash_prog_addr,
  input wire logic [7:0] flash_prog_data
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  logic [15:0] stall_cnt_q;
  assign ctrl_wr = psel && penable && pwrite && paddr == FWP_OFS_CTRL;
  // Counter, since a repetition of the full write time is too long
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) stall_cnt_q <= 16'h0;
    else if (cpu_stall) stall_cnt_q <= stall_cnt_q + 16'h1;
    else stall_cnt_q <= 16'h0;
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  key_reads_zero_a: assert property (pready && !pwrite && paddr == FWP_OFS_KEY |-> prdata == 32'h0)
    else $error("key port read not zero");
  ctrl_spare_a: assert property (pready && !pwrite && paddr == FWP_OFS_CTRL |-> prdata[31:6] == 26'h0 && !prdata[0])
    else $error("unused control bits set");
  stall_cause_a: assert property ($rose(cpu_stall) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("stall without start write");
  prog_follows_a: assert property ($rose(cpu_stall) |-> ##[1:2] flash_prog_en)
    else $error("no program pulse after start");
  prog_in_stall_a: assert property (flash_prog_en |-> cpu_stall)
    else $error("program pulse outside stall");
  stall_bound_a: assert property (cpu_stall |-> stall_cnt_q < WRITE_CYCLES)
    else $error("stall too long");
  abort_stops_a: assert property (cpu_stall && (external_reset_pin || watchdog_timer) |=> !cpu_stall)
    else $error("abort did not end stall");
  addr_step_a: assert property (flash_prog_en && $past(flash_prog_en) |-> flash_prog_addr == $past(flash_prog_addr) + 22'h1)
    else $error("program address skipped");
  word_even_a: assert property ($rose(flash_prog_en) |-> !flash_prog_addr[0])
    else $error("first program address odd");
endmodule // fwp_asserts
bind fwp_flash_word_program_control fwp_asserts #(.WRITE_CYCLES(WRITE_CYCLES))
  fwp_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_reset_pin(external_reset_pin), .watchdog_timer(watchdog_timer),
  .cpu_stall(cpu_stall), .flash_prog_en(flash_prog_en),
  .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data));
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the flash word program control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fwp_pkg::*;
  // Must exceed the 64 block pulses
  localparam int WCYC = 80;
  logic clk_sys, rst_n, psel, penable, pwrite, ext_rst, wdog, perr;
  logic pready, pslverr, cpu_stall, flash_prog_en;
  logic [7:0] paddr, flash_prog_data;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] flash_prog_addr;
  logic [21:0] pa[$];
  logic [7:0] pd[$];
  int n_fail = 0, total_checks = 0, stall_n = 0, cyc = 0;
  fwp_flash_word_program_control #(.WRITE_CYCLES(WCYC))
    fwp_flash_word_program_control_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin(ext_rst), .watchdog_timer(wdog),
    .cpu_stall(cpu_stall), .flash_prog_en(flash_prog_en),
    .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data));
  // ----
  // Clock, monitor, tasks
  // ----
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (flash_prog_en) pa.push_back(flash_prog_addr);
    if (flash_prog_en) pd.push_back(flash_prog_data);
    if (cpu_stall) stall_n <= stall_n + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Releases, then idles a cycle so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // Ready, data and error are taken at the rising edge that sees ready
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic run_prog(input logic [7:0] en, input int src);
    int t;
    t = 0;
    pa.delete();
    pd.delete();
    stall_n = 0;
    apb(1, FWP_OFS_CTRL, {24'h0, en});
    apb(1, FWP_OFS_KEY, 32'h55);
    apb(1, FWP_OFS_KEY, 32'haa);
    apb(1, FWP_OFS_CTRL, {24'h0, en | 8'h02});
    if (src != 0) begin
      repeat (4) @(posedge clk_sys);
      ext_rst <= (src == 1);
      wdog <= (src == 2);
      @(posedge clk_sys);
      ext_rst <= 0;
      wdog <= 0;
    end
    while (cpu_stall !== 1'b0 && t < 200) begin
      @(posedge clk_sys);
      t++;
    end
    repeat (2) @(posedge clk_sys);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    {psel, penable, pwrite, ext_rst, wdog, rst_n} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rdchk("ctrl rst", FWP_OFS_CTRL, 32'h0);
    apb(1, FWP_OFS_PTR_UPPER, 32'hff);
    rdchk("ptr upper", FWP_OFS_PTR_UPPER, 32'h3f);
    apb(1, FWP_OFS_PTR_UPPER, 32'h01);
    apb(1, FWP_OFS_PTR_HIGH, 32'h12);
    apb(1, FWP_OFS_PTR_LOW, 32'h00);
    rdchk("ptr high", FWP_OFS_PTR_HIGH, 32'h12);
    apb(1, FWP_OFS_KEY, 32'h55);
    rdchk("key port", FWP_OFS_KEY, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    // Error bit ignores a written one
    apb(1, FWP_OFS_CTRL, 32'hc9);
    rdchk("ctrl spare", FWP_OFS_CTRL, 32'h0);
    apb(1, FWP_OFS_LATCH, 32'ha5);
    apb(1, FWP_OFS_TABLE_WRITE_INSTRUCTION, 32'h1);
    apb(1, FWP_OFS_LATCH, 32'h5a);
    apb(1, FWP_OFS_TABLE_WRITE_INSTRUCTION, 32'h0);
    rdchk("ptr inc", FWP_OFS_PTR_LOW, 32'h01);
    rdchk("hold 1", FWP_OFS_HOLD_BASE + 8'h04, 32'h5a);
    apb(1, FWP_OFS_CTRL, 32'h24);
    apb(1, FWP_OFS_KEY, 32'haa);
    apb(1, FWP_OFS_KEY, 32'h55);
    apb(1, FWP_OFS_CTRL, 32'h26);
    chk("key order", 32'h0, {31'h0, cpu_stall});
    rdchk("busy", FWP_OFS_STATUS, 32'h0);
    run_prog(8'h24, 0);
    chk("word bytes", 32'h2, 32'(pa.size()));
    chk("addr 0", 32'h011200, {10'h0, pa[0]});
    chk("addr 1", 32'h011201, {10'h0, pa[1]});
    chk("data", 32'ha55a, {16'h0, pd[0], pd[1]});
    chk("stall", WCYC, stall_n);
    rdchk("done", FWP_OFS_CTRL, 32'h24);
    rdchk("hold kept", FWP_OFS_HOLD_BASE, 32'ha5);
    run_prog(8'h04, 0);
    chk("block bytes", 32'd64, 32'(pa.size()));
    for (int s = 1; s < 3; s++) begin
      run_prog(8'h24, s);
      rdchk("abort err", FWP_OFS_CTRL, 32'h2c);
      rdchk("abort verify", FWP_OFS_HOLD_BASE, 32'ha5);
      apb(1, FWP_OFS_CTRL, 32'h24);
      rdchk("err clear", FWP_OFS_CTRL, 32'h24);
    end
    apb(1, FWP_OFS_CTRL, 32'h0);
    rdchk("enables off", FWP_OFS_CTRL, 32'h0);
    close_out();
  end
endmodule // tb_top
`default_nettype wire

// ### src/fwp_flash_word_program_control.sv
// Flash word program sequencer with APB register access
// Function
// R1: Word mode programs exactly two bytes
// R2: Software programs only erased words
// R3: Software loads pointer and holding bytes first
// R4: Software sets word enable then write enable
// R5: Start accepted only after 55h then AAh
// R6: Start bit after unlock begins programming
// R7: Stall processor until write timer ends
// R8: Reset pin or watchdog abort sets error
// R9: Software verifies and reprograms after abort
// R10: Key register holds no stored value
// R11: Control bits 5..1, others read zero
// R12: Pointer split over upper, high, low bytes
// R13: Latch byte feeds each table write
// R14: Software clears enables after completion
// R15: Holding registers keep contents after write
// R16: Start bit clears when programming completes
`timescale 1ns/1ps
`default_nettype none

module fwp_flash_word_program_control
  import fwp_pkg::*;
#(
  parameter int WRITE_CYCLES = FWP_WORD_WRITE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  output logic cpu_stall,
  output logic flash_prog_en,
  output logic [21:0] flash_prog_addr,
  output logic [7:0] flash_prog_data
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [21:0] table_pointer_q;
  logic [7:0] table_latch_byte_q;
  logic single_word_program_enable_q;
  logic erase_sel_q;
  logic aborted_write_error_flag_q;
  logic memory_write_enable_q;
  logic wr_start_q;
  fwp_key_state_t key_q;
  fwp_prog_t prog_q;
  logic [31:0] timer_q;
  logic [7:0] hold_q [FWP_HOLD_DEPTH];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic stall_q;
  logic pen_q;
  logic [21:0] paddr_q;
  logic [7:0] pdata_q;

  logic acc;
  logic wr_acc;
  logic rd_setup;
  logic start_req;
  logic abort_evt;
  logic tick_done;
  logic [7:0] ctrl_rd;
  logic [5:0] hidx;
  logic mapped;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // No wait state: ready is asserted in the cycle after setup
  assign acc = psel & penable & pready_q;
  assign wr_acc = acc & pwrite;
  assign rd_setup = psel & ~penable;
  assign hidx = paddr[7:2] - 6'h10;
  assign mapped = (paddr[1:0] == 2'b00) &&
                  ((paddr <= FWP_OFS_STATUS) || (paddr >= FWP_OFS_HOLD_BASE));
  // Watchdog or reset pin cutting a busy write
  assign abort_evt = prog_q.busy & (external_reset_pin | watchdog_timer);
  assign tick_done = prog_q.busy && (timer_q == 32'h0);
  assign start_req = wr_acc && (paddr == FWP_OFS_CTRL) &&
                     pwdata[FWP_BIT_WR_START] && (key_q == FWP_KEY_OPEN) &&
                     pwdata[FWP_BIT_WR_EN] && memory_write_enable_q &&
                     !prog_q.busy;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[FWP_BIT_WORD_EN] = single_word_program_enable_q; // R11
    ctrl_rd[FWP_BIT_ERASE_SEL] = erase_sel_q; // R11
    ctrl_rd[FWP_BIT_WR_ERR] = aborted_write_error_flag_q; // R11
    ctrl_rd[FWP_BIT_WR_EN] = memory_write_enable_q; // R11
    ctrl_rd[FWP_BIT_WR_START] = wr_start_q; // R11
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= rd_setup;
      pslverr_q <= rd_setup & ~mapped;
      prdata_q <= 32'h0;
      if (rd_setup && !pwrite) begin
        if (paddr >= FWP_OFS_HOLD_BASE) begin
          prdata_q <= {24'h0, hold_q[hidx]};
        end else begin
          case (paddr)
            FWP_OFS_PTR_UPPER: prdata_q <= {26'h0, table_pointer_q[21:16]}; // R12
            FWP_OFS_PTR_HIGH: prdata_q <= {24'h0, table_pointer_q[15:8]}; // R12
            FWP_OFS_PTR_LOW: prdata_q <= {24'h0, table_pointer_q[7:0]}; // R12
            FWP_OFS_LATCH: prdata_q <= {24'h0, table_latch_byte_q};
            FWP_OFS_CTRL: prdata_q <= {24'h0, ctrl_rd};
            FWP_OFS_STATUS: prdata_q <= {31'h0, prog_q.busy};
            default: prdata_q <= 32'h0; // R10
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Table pointer and latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer_q <= FWP_RST_PTR;
      table_latch_byte_q <= FWP_RST_BYTE;
    end else if (wr_acc && !prog_q.busy) begin
      case (paddr)
        FWP_OFS_PTR_UPPER: table_pointer_q[21:16] <= pwdata[5:0]; // R12
        FWP_OFS_PTR_HIGH: table_pointer_q[15:8] <= pwdata[7:0]; // R12
        FWP_OFS_PTR_LOW: table_pointer_q[7:0] <= pwdata[7:0]; // R12
        FWP_OFS_LATCH: table_latch_byte_q <= pwdata[7:0];
        FWP_OFS_TABLE_WRITE_INSTRUCTION: begin
          if (pwdata[FWP_BIT_TABLE_WRITE_INSTRUCTION_INC]) begin
            table_pointer_q <= table_pointer_q + 22'h1;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Holding registers, never cleared by a write
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < FWP_HOLD_DEPTH; i++) begin : g_hold
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          hold_q[i] <= FWP_RST_BYTE;
        end else if (wr_acc && !prog_q.busy && (paddr == FWP_OFS_TABLE_WRITE_INSTRUCTION) &&
                     (table_pointer_q[5:0] == 6'(i))) begin
          hold_q[i] <= table_latch_byte_q; // R13 R15
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Unlock key tracker
  // ----------------------------------------------------------------
  // No data is kept; only the sequence position advances
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= FWP_KEY_IDLE;
    end else if (wr_acc) begin
      if (paddr == FWP_OFS_KEY) begin
        case (key_q)
          FWP_KEY_IDLE: key_q <= (pwdata[7:0] == FWP_KEY_FIRST) ?
                                 FWP_KEY_GOT_FIRST : FWP_KEY_IDLE; // R5 R10
          FWP_KEY_GOT_FIRST: key_q <= (pwdata[7:0] == FWP_KEY_SECOND) ?
                                      FWP_KEY_OPEN : FWP_KEY_IDLE; // R5 R10
          default: key_q <= FWP_KEY_IDLE;
        endcase
      end else begin
        // Any other write breaks the unlock, so start must follow at once
        key_q <= FWP_KEY_IDLE; // R5
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      single_word_program_enable_q <= 1'b0;
      erase_sel_q <= 1'b0;
      memory_write_enable_q <= 1'b0;
      wr_start_q <= 1'b0;
    end else begin
      if (wr_acc && (paddr == FWP_OFS_CTRL) && !prog_q.busy) begin
        single_word_program_enable_q <= pwdata[FWP_BIT_WORD_EN];
        erase_sel_q <= pwdata[FWP_BIT_ERASE_SEL];
        memory_write_enable_q <= pwdata[FWP_BIT_WR_EN];
      end
      if (start_req) begin
        wr_start_q <= 1'b1; // R6
      end else if (tick_done || abort_evt) begin
        wr_start_q <= 1'b0; // R16
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aborted_write_error_flag_q <= 1'b0;
    end else if (abort_evt) begin
      aborted_write_error_flag_q <= 1'b1; // R8
    end else if (wr_acc && (paddr == FWP_OFS_CTRL) &&
                 !pwdata[FWP_BIT_WR_ERR]) begin
      aborted_write_error_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Programming sequencer and write timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_q <= '0;
      timer_q <= 32'h0;
      stall_q <= 1'b0;
      pen_q <= 1'b0;
      paddr_q <= FWP_RST_PTR;
      pdata_q <= FWP_RST_BYTE;
    end else begin
      pen_q <= 1'b0;
      if (start_req) begin
        prog_q.busy <= 1'b1; // R6
        prog_q.addr <= single_word_program_enable_q ?
                       {table_pointer_q[21:1], 1'b0} :
                       {table_pointer_q[21:6], 6'h00};
        prog_q.count <= single_word_program_enable_q ?
                        6'(FWP_WORD_BYTES - 1) :
                        6'(FWP_HOLD_DEPTH - 1); // R1
        timer_q <= WRITE_CYCLES - 1;
        stall_q <= 1'b1; // R7
      end else if (abort_evt || tick_done) begin
        prog_q.busy <= 1'b0;
        stall_q <= 1'b0; // R7
      end else if (prog_q.busy) begin
        timer_q <= timer_q - 32'h1;
        if (pen_q || (timer_q == WRITE_CYCLES - 1)) begin
          // One byte per cycle to the array, then wait out the timer
          if (!(pen_q && prog_q.count == 6'h0)) begin
            pen_q <= 1'b1;
            paddr_q <= prog_q.addr;
            pdata_q <= hold_q[prog_q.addr[5:0]]; // R1
            prog_q.addr <= prog_q.addr + 22'h1;
            if (pen_q) begin
              prog_q.count <= prog_q.count - 6'h1;
            end
          end
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_stall = stall_q;
  assign flash_prog_en = pen_q;
  assign flash_prog_addr = paddr_q;
  assign flash_prog_data = pdata_q;

endmodule // fwp_flash_word_program_control

`default_nettype wire

// ### src/fwp_pkg.sv
// Package for the flash word program control block
package fwp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses (APB, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] FWP_OFS_PTR_UPPER = 8'h00;
  localparam logic [7:0] FWP_OFS_PTR_HIGH = 8'h04;
  localparam logic [7:0] FWP_OFS_PTR_LOW = 8'h08;
  localparam logic [7:0] FWP_OFS_LATCH = 8'h0c;
  localparam logic [7:0] FWP_OFS_KEY = 8'h10;
  localparam logic [7:0] FWP_OFS_CTRL = 8'h14;
  localparam logic [7:0] FWP_OFS_TABLE_WRITE_INSTRUCTION = 8'h18;
  localparam logic [7:0] FWP_OFS_STATUS = 8'h1c;
  localparam logic [7:0] FWP_OFS_HOLD_BASE = 8'h40;

  // ----------------------------------------------------------------
  // Control and table write register field positions
  // ----------------------------------------------------------------
  localparam int FWP_BIT_WORD_EN = 5;
  localparam int FWP_BIT_ERASE_SEL = 4;
  localparam int FWP_BIT_WR_ERR = 3;
  localparam int FWP_BIT_WR_EN = 2;
  localparam int FWP_BIT_WR_START = 1;
  localparam int FWP_BIT_TABLE_WRITE_INSTRUCTION_INC = 0;

  // ----------------------------------------------------------------
  // Reset values, keys, sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] FWP_RST_BYTE = 8'h00;
  localparam logic [21:0] FWP_RST_PTR = 22'h000000;
  localparam logic [7:0] FWP_KEY_FIRST = 8'h55;
  localparam logic [7:0] FWP_KEY_SECOND = 8'haa;
  localparam int FWP_HOLD_DEPTH = 64;
  localparam int FWP_WORD_BYTES = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FWP_CLK_NS = 100;
  localparam int FWP_WORD_WRITE_US = 2800;
  localparam int FWP_WORD_WRITE_CYC = (FWP_WORD_WRITE_US * 1000) / FWP_CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FWP_KEY_IDLE,
    FWP_KEY_GOT_FIRST,
    FWP_KEY_OPEN
  } fwp_key_state_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [5:0] count;
    logic busy;
  } fwp_prog_t;

endpackage : fwp_pkg
